// ### verilog/flash_command_sequencer.sv
/*
  Flash command sequencer: register port, three-step command write sequence,
  two-stage command queue, execution engine and timing clock divider.
  Assumes a flash core that performs one word operation per op_start pulse and
  answers with op_done, and an external protection checker.
*/
`timescale 1ns/1ns
`include "flash_seq_regs.svh"

module flash_command_sequencer
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = 10
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              array_wr,
  input  wire logic [15:0]       array_addr,
  input  wire logic [15:0]       array_wdata,
  input  wire logic              array_word,
  input  wire logic              special_mode,
  input  wire logic              protect_hit,
  input  wire logic              protect_any,
  input  wire logic              other_bank_error,
  output logic                   timing_clock,
  output logic                   op_start,
  output logic      [7:0]        op_command,
  output logic      [15:0]       op_addr,
  output logic      [15:0]       op_data,
  input  wire logic              op_done,
  input  wire logic              op_blank,
  output logic                   hv_keep
);

  // Register port decode
  logic wr_div, wr_stat, wr_cmd, wr_addr_hi, wr_addr_lo;
  assign wr_div     = reg_wr && reg_addr == `OFS_DIVIDER;
  assign wr_stat    = reg_wr && reg_addr == `OFS_STATUS;
  assign wr_cmd     = reg_wr && reg_addr == `OFS_COMMAND;
  assign wr_addr_hi = reg_wr && reg_addr == `OFS_ADDR_HIGH;
  assign wr_addr_lo = reg_wr && reg_addr == `OFS_ADDR_LOW;

  function automatic logic valid_user_cmd(input logic [7:0] c);
    valid_user_cmd = c == `CMD_ERASE_VERIFY || c == `CMD_PROGRAM ||
                     c == `CMD_SECTOR_ERASE || c == `CMD_MASS_ERASE;
  endfunction

  // State registers
  seq_state_t  seq_reg;
  exe_state_t  exe_reg;
  logic        div_loaded_reg;
  logic        prescale_reg;
  logic [5:0]  div_value_reg;
  logic        buf_empty_reg;
  logic        cmd_done_reg;
  logic        acc_err_reg;
  logic        prot_viol_reg;
  logic        blank_reg;
  logic [7:0]  buf_cmd_reg;
  logic [15:0] buf_addr_reg;
  logic [15:0] buf_data_reg;
  logic        pend_reg;
  logic        act_reg;
  logic [7:0]  act_cmd_reg;
  logic [15:0] act_addr_reg;
  logic [15:0] act_data_reg;
  logic [8:0]  words_left_reg;

  // Sequence events
  logic launch_req, launch_ok, seq_error, any_reg_write, move_to_active, act_finish;
  assign any_reg_write = reg_wr;
  assign launch_req    = wr_stat && reg_wdata[`ST_BUF_EMPTY_BIT] && seq_reg == SEQ_CMD;
  assign launch_ok     = launch_req && div_loaded_reg && !acc_err_reg && !prot_viol_reg
                         && !other_bank_error;
  assign move_to_active = pend_reg && !act_reg;
  assign act_finish     = exe_reg == EXE_WAIT && op_done && words_left_reg == 9'h001;

  // Illegal operations in the write sequence
  always_comb
  begin
    seq_error = 1'b0;
    if (array_wr)
    begin
      // Array write before divider load, off-sequence, with the buffer full, or not a whole aligned word
      if (!div_loaded_reg || seq_reg != SEQ_IDLE || !buf_empty_reg ||
          !array_word || array_addr[0])
        seq_error = 1'b1;
    end
    if (wr_stat && !reg_wdata[`ST_BUF_EMPTY_BIT] && seq_reg != SEQ_IDLE)
      seq_error = 1'b1;
    if (launch_req && !launch_ok)
      seq_error = 1'b1;
    if (seq_reg == SEQ_WORD && any_reg_write && !wr_cmd)
      seq_error = 1'b1;
    if (wr_cmd && seq_reg != SEQ_WORD)
      seq_error = 1'b1;
    if (wr_cmd && seq_reg == SEQ_WORD && !special_mode && !valid_user_cmd(reg_wdata))
      seq_error = 1'b1;
    if (seq_reg == SEQ_CMD && any_reg_write && !wr_stat)
      seq_error = 1'b1;
  end

  // Protection violations found at word write or mass erase command
  logic prot_error;
  assign prot_error = (array_wr && !seq_error && protect_hit) ||
                      (wr_cmd && seq_reg == SEQ_WORD && !seq_error &&
                       reg_wdata == `CMD_MASS_ERASE && protect_any);

  // Sequence position; reads never change it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      seq_reg <= SEQ_IDLE;
    else if (seq_error || prot_error)
      seq_reg <= SEQ_IDLE;
    else if (array_wr)
      seq_reg <= SEQ_WORD;
    else if (wr_cmd)
      seq_reg <= SEQ_CMD;
    else if (launch_ok)
      seq_reg <= SEQ_IDLE;
  end

  // Buffer stage: word write latches address and data, then the command
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_cmd_reg  <= 8'h00;
      buf_addr_reg <= 16'h0000;
      buf_data_reg <= 16'h0000;
    end
    else
    begin
      if (array_wr && !seq_error)
      begin
        buf_addr_reg <= array_addr;
        buf_data_reg <= array_wdata;
      end
      else if (special_mode && seq_reg == SEQ_IDLE && wr_addr_hi)
        buf_addr_reg[15:8] <= reg_wdata & `ADDR_HIGH_MASK;
      else if (special_mode && seq_reg == SEQ_IDLE && wr_addr_lo)
        buf_addr_reg[7:0] <= reg_wdata;
      if (wr_cmd && seq_reg == SEQ_WORD && !seq_error)
        buf_cmd_reg <= reg_wdata & `CMD_BITS_MASK;
    end
  end

  // Pending flag of the buffer stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pend_reg <= 1'b0;
    else if (launch_ok)
      pend_reg <= 1'b1;
    else if (move_to_active)
      pend_reg <= 1'b0;
  end

  // Buffer-empty flag: cleared by launch, set when buffer drains to active
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      buf_empty_reg <= 1'b1;
    else if (launch_ok)
      buf_empty_reg <= 1'b0;
    else if (move_to_active)
      buf_empty_reg <= 1'b1;
  end

  // Command-complete flag: only when active done and nothing pending
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cmd_done_reg <= 1'b1;
    else if (launch_ok)
      cmd_done_reg <= 1'b0;
    else if (act_finish && !pend_reg)
      cmd_done_reg <= 1'b1;
  end

  // Error flags: write one clears, a new event wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_err_reg   <= 1'b0;
      prot_viol_reg <= 1'b0;
    end
    else
    begin
      if (seq_error)
        acc_err_reg <= 1'b1;
      else if (wr_stat && reg_wdata[`ST_ACC_ERR_BIT])
        acc_err_reg <= 1'b0;
      if (prot_error)
        prot_viol_reg <= 1'b1;
      else if (wr_stat && reg_wdata[`ST_PROT_VIOL_BIT])
        prot_viol_reg <= 1'b0;
    end
  end

  // Blank flag: cleared on launch, set by a passing erase verify
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      blank_reg <= 1'b0;
    else if (launch_ok)
      blank_reg <= 1'b0;
    else if (act_finish && act_cmd_reg == `CMD_ERASE_VERIFY && op_blank)
      blank_reg <= 1'b1;
  end

  // Active stage and word walk of the execution engine
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_reg        <= 1'b0;
      act_cmd_reg    <= 8'h00;
      act_addr_reg   <= 16'h0000;
      act_data_reg   <= 16'h0000;
      words_left_reg <= 9'h000;
      exe_reg        <= EXE_IDLE;
    end
    else
    begin
      unique case (exe_reg)
        EXE_IDLE:
        begin
          if (move_to_active)
          begin
            act_reg     <= 1'b1;
            act_cmd_reg <= buf_cmd_reg;
            act_data_reg <= buf_data_reg;
            exe_reg     <= EXE_ISSUE;
            if (buf_cmd_reg == `CMD_SECTOR_ERASE)
            begin
              act_addr_reg   <= {buf_addr_reg[15:`SECTOR_LOW_BITS], `SECTOR_LOW_BITS'(0)};
              words_left_reg <= `SECTOR_WORDS;
            end
            else
            begin
              act_addr_reg   <= buf_addr_reg;
              words_left_reg <= 9'h001;
            end
          end
        end
        EXE_ISSUE:
          exe_reg <= EXE_WAIT;
        EXE_WAIT:
        begin
          if (op_done)
          begin
            if (words_left_reg == 9'h001)
            begin
              act_reg <= 1'b0;
              exe_reg <= EXE_IDLE;
            end
            else
            begin
              words_left_reg <= words_left_reg - 9'h001;
              act_addr_reg   <= act_addr_reg + 16'h0002;
              exe_reg        <= EXE_ISSUE;
            end
          end
        end
        default:
          exe_reg <= EXE_IDLE;
      endcase
    end
  end

  // Operation outputs to the flash core
  assign op_start   = exe_reg == EXE_ISSUE;
  assign op_command = act_cmd_reg;
  assign op_addr    = act_addr_reg;
  assign op_data    = act_cmd_reg == `CMD_PROGRAM ? act_data_reg : 16'h0000;

  // Keep high voltage between two programs on one row
  assign hv_keep = act_reg && pend_reg && act_cmd_reg == `CMD_PROGRAM && buf_cmd_reg == `CMD_PROGRAM &&
                   act_addr_reg[15:`ROW_LOW_BITS] == buf_addr_reg[15:`ROW_LOW_BITS];

  // Divider register; any write marks it loaded
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_loaded_reg <= 1'b0;
      prescale_reg   <= 1'b0;
      div_value_reg  <= 6'h00;
    end
    else if (wr_div)
    begin
      div_loaded_reg <= 1'b1;
      prescale_reg   <= reg_wdata[`DIV_PRESCALE_BIT];
      div_value_reg  <= reg_wdata[5:0];
    end
  end

  // Timing clock: optional divide by eight, then by field plus one
  logic [2:0] pre_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic       pre_tick;
  assign pre_tick = !prescale_reg || pre_cnt_reg == `DIV_PRESCALE_RATIO;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_reg  <= 3'h0;
      div_cnt_reg  <= 6'h00;
      timing_clock <= 1'b0;
    end
    else
    begin
      pre_cnt_reg  <= prescale_reg ? pre_cnt_reg + 3'h1 : 3'h0;
      timing_clock <= 1'b0;
      if (pre_tick)
      begin
        if (div_cnt_reg >= div_value_reg)
        begin
          div_cnt_reg  <= 6'h00;
          timing_clock <= div_loaded_reg;
        end
        else
          div_cnt_reg <= div_cnt_reg + 6'h01;
      end
    end
  end

  // Read data, one cycle after the read strobe
  logic [7:0] rd_value;
  always_comb
  begin
    rd_value = 8'h00;
    unique case (reg_addr)
      `OFS_DIVIDER:      rd_value = {div_loaded_reg, prescale_reg, div_value_reg};
      `OFS_STATUS:       rd_value = {buf_empty_reg, cmd_done_reg, prot_viol_reg, acc_err_reg,
                                     1'b0, blank_reg, 2'b00};
      `OFS_COMMAND:      rd_value = seq_reg != SEQ_IDLE ? buf_cmd_reg : 8'h00;
      `OFS_FACTORY_TEST: rd_value = 8'h00;
      `OFS_ADDR_HIGH:    rd_value = special_mode ? buf_addr_reg[15:8] & `ADDR_HIGH_MASK : 8'h00;
      `OFS_ADDR_LOW:     rd_value = special_mode ? buf_addr_reg[7:0] : 8'h00;
      `OFS_DATA_HIGH:    rd_value = special_mode ? buf_data_reg[15:8] : 8'h00;
      `OFS_DATA_LOW:     rd_value = special_mode ? buf_data_reg[7:0] : 8'h00;
      default:           rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_value : 8'h00;
  end

endmodule

// ### verilog/flash_seq_regs.svh
/*
  Register offsets, field positions and command codes of the
  flash command sequencer. Assumes byte offsets on an 8-bit register port.
*/
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// Register byte offsets
`define OFS_DIVIDER        10'h100
`define OFS_STATUS         10'h105
`define OFS_COMMAND        10'h106
`define OFS_FACTORY_TEST   10'h107
`define OFS_ADDR_HIGH      10'h108
`define OFS_ADDR_LOW       10'h109
`define OFS_DATA_HIGH      10'h10A
`define OFS_DATA_LOW       10'h10B

// Divider register fields
`define DIV_LOADED_BIT     7
`define DIV_PRESCALE_BIT   6
`define DIV_PRESCALE_RATIO 3'h7

// Status register fields
`define ST_BUF_EMPTY_BIT   7
`define ST_CMD_DONE_BIT    6
`define ST_PROT_VIOL_BIT   5
`define ST_ACC_ERR_BIT     4
`define ST_BLANK_BIT       2

// Command register writable bits and user command codes
`define CMD_BITS_MASK      8'h65
`define CMD_ERASE_VERIFY   8'h05
`define CMD_PROGRAM        8'h20
`define CMD_SECTOR_ERASE   8'h40
`define CMD_MASS_ERASE     8'h41

// Address layout
`define ADDR_HIGH_MASK     8'h7F
`define SECTOR_LOW_BITS    9
`define SECTOR_WORDS       9'h100
`define ROW_LOW_BITS       6

`endif

// ### verilog/flash_seq_pkg.sv
/*
  Types of the flash command sequencer.
  Assumes flash_seq_regs.svh is included by the design file.
*/
package flash_seq_pkg;

  // Command write sequence position
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WORD = 2'b01,
    SEQ_CMD  = 2'b10
  } seq_state_t;

  // Execution engine position
  typedef enum logic [1:0] {
    EXE_IDLE  = 2'b00,
    EXE_ISSUE = 2'b01,
    EXE_WAIT  = 2'b10
  } exe_state_t;

endpackage

// ### test/flash_core_model.sv
/*
  Behavioural flash core: one word operation per op_start, answered by op_done.
  Assumes the sequencer's clock and reset; slow selects a long operation time.
*/
`timescale 1ns/1ns

module flash_core_model
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic op_start,
  input  wire logic slow,
  input  wire logic blank,
  output logic      op_done,
  output logic      op_blank
);
  logic       busy;
  logic       tog;
  logic [5:0] wait_cnt;

  // One word per request, done pulse after the chosen delay
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      busy     <= 1'b0;
      wait_cnt <= 6'h00;
      op_done  <= 1'b0;
      tog      <= 1'b0;
    end
    else
    begin
      op_done <= 1'b0;
      tog     <= ~tog;
      if (op_start)
      begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 6'h28 : 6'h01;
      end
      else if (busy && wait_cnt == 6'h00)
      begin
        busy    <= 1'b0;
        op_done <= 1'b1;
      end
      else if (busy)
        wait_cnt <= wait_cnt - 6'h01;
    end

  // Blank result only valid beside op_done, toggles otherwise
  assign op_blank = op_done ? blank : tog;
endmodule

// ### test/flash_command_sequencer_checker.sv
/*
  Port-level assertions of the flash command sequencer.
  Assumes it is bound to the top module and the register header is on the path.
*/
`timescale 1ns/1ns
`include "flash_seq_regs.svh"

module flash_command_sequencer_checker
#(
  parameter int ADDR_W = 10
)
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              special_mode,
  input wire logic              timing_clock,
  input wire logic              op_start,
  input wire logic [7:0]        op_command,
  input wire logic [15:0]       op_addr,
  input wire logic [15:0]       op_data
);
  logic       div_wr;
  logic       div_seen;
  logic       clean;
  logic [9:0] gap;
  logic [9:0] ratio;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence rd_at(a);
    reg_rd && reg_addr == a;
  endsequence

  // Divider write detection
  assign div_wr = reg_wr && reg_addr == `OFS_DIVIDER;

  // Loaded flag and expected tick ratio
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      div_seen <= 1'b0;
      ratio    <= 10'h001;
    end
    else if (div_wr)
    begin
      div_seen <= 1'b1;
      ratio    <= (reg_wdata[6] ? 10'h008 : 10'h001) * ({4'h0, reg_wdata[5:0]} + 10'h001);
    end

  // Cycles since last tick; clean once a tick follows the divider write
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      gap   <= 10'h000;
      clean <= 1'b0;
    end
    else
    begin
      gap   <= timing_clock ? 10'h000 : gap + 10'h001;
      clean <= div_wr ? 1'b0 : (timing_clock | clean);
    end

  idle_rdata_a:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero outside read");
  cmd_bits_a:
    assert property (rd_at(`OFS_COMMAND) |=> (reg_rdata & ~`CMD_BITS_MASK) == 8'h00)
    else $error("fixed command bits not zero");
  factory_zero_a:
    assert property (rd_at(`OFS_FACTORY_TEST) |=> reg_rdata == 8'h00) else $error("test register not zero");
  user_addr_a:
    assert property (!special_mode ##0 (rd_at(`OFS_ADDR_HIGH) or rd_at(`OFS_ADDR_LOW)) |=> reg_rdata == 8'h00)
    else $error("address visible in user mode");
  addr_mask_a:
    assert property (rd_at(`OFS_ADDR_HIGH) |=> !reg_rdata[7]) else $error("unused address bit set");
  user_data_a:
    assert property (!special_mode ##0 (rd_at(`OFS_DATA_HIGH) or rd_at(`OFS_DATA_LOW)) |=> reg_rdata == 8'h00)
    else $error("data visible in user mode");
  status_zero_a:
    assert property (rd_at(`OFS_STATUS) |=> reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'b00)
    else $error("unused status bits set");
  user_codes_a:
    assert property (op_start && !special_mode |-> op_command inside {`CMD_ERASE_VERIFY, `CMD_PROGRAM,
      `CMD_SECTOR_ERASE, `CMD_MASS_ERASE}) else $error("illegal command executed");
  erase_data_a:
    assert property (op_start && op_command != `CMD_PROGRAM |-> op_data == 16'h0000)
    else $error("erase carries data");
  word_op_a:
    assert property (op_start |-> !op_addr[0] ##1 !op_start) else $error("operation not one aligned word");
  no_divider_a:
    assert property (!div_seen |-> !timing_clock && !op_start) else $error("activity before divider load");
  tick_period_a:
    assert property (timing_clock && clean |-> gap == ratio - 10'h001) else $error("timing clock period wrong");
endmodule

bind flash_command_sequencer flash_command_sequencer_checker #(.ADDR_W(ADDR_W)) u_checker (
  .clk_sys      (clk_sys),
  .rst_n        (rst_n),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rdata    (reg_rdata),
  .special_mode (special_mode),
  .timing_clock (timing_clock),
  .op_start     (op_start),
  .op_command   (op_command),
  .op_addr      (op_addr),
  .op_data      (op_data)
);

// ### test/flash_command_sequencer_tb_top.sv
/*
  Self-checking bench of the flash command sequencer driven over its register port.
  Assumes the core model and the bound checker are compiled beside it.
*/
`timescale 1ns/1ns
`include "flash_seq_regs.svh"
`define CHECK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_mismatch++; $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module flash_command_sequencer_tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, array_wr = 1'b0, array_word = 1'b1;
  logic special_mode = 1'b0, protect_hit = 1'b0, protect_any = 1'b0, other_bank_error = 1'b0, slow = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, op_command, last_cmd;
  logic [15:0] array_addr = 16'h0000, array_wdata = 16'h0000, op_addr, op_data, first_addr, last_data;
  logic timing_clock, op_start, op_done, op_blank, hv_keep;
  int n_mismatch = 0, checked = 0, n_op = 0, cyc = 0, i;
  logic [7:0] codes [4] = '{8'h20, 8'h40, 8'h05, 8'h41};
  logic [15:0] addrs [4] = '{16'h4002, 16'h45A6, 16'h4000, 16'h6000}; // Fixed range, no page select

  flash_command_sequencer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .array_wr(array_wr), .array_addr(array_addr),
    .array_wdata(array_wdata), .array_word(array_word), .special_mode(special_mode), .protect_hit(protect_hit),
    .protect_any(protect_any), .other_bank_error(other_bank_error), .timing_clock(timing_clock),
    .op_start(op_start), .op_command(op_command), .op_addr(op_addr), .op_data(op_data), .op_done(op_done),
    .op_blank(op_blank), .hv_keep(hv_keep));
  flash_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .op_start(op_start), .slow(slow), .blank(1'b1),
    .op_done(op_done), .op_blank(op_blank));

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  // Record every core operation at mid-cycle, where its outputs are settled
  always @(negedge clk_sys)
    if (op_start === 1'b1)
    begin
      if (n_op == 0) first_addr = op_addr;
      n_op++;
      last_cmd = op_command;
      last_data = op_data;
    end

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      print_verdict;
    end
  end

  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task rd_chk(input logic [9:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHECK(nm, e, d)
  endtask

  task aw(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    array_wr <= 1'b1;
    array_addr <= a;
    array_wdata <= d;
    @(posedge clk_sys);
    array_wr <= 1'b0;
  endtask

  // Word, command, launch with nothing in between
  task seq(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    aw(a, d);
    wr(`OFS_COMMAND, c);
    wr(`OFS_STATUS, 8'h80);
  endtask

  task wait_done;
    logic [7:0] d;
    d = 8'h00;
    for (int k = 0; k < 5000 && d[6] !== 1'b1; k++) rd(`OFS_STATUS, d);
    `CHECK("cmd_done", 1'b1, d[6])
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`OFS_STATUS, 8'hC0, "status_reset");
    rd_chk(`OFS_DIVIDER, 8'h00, "divider_reset");
    wr(`OFS_FACTORY_TEST, 8'hFF);
    rd_chk(`OFS_FACTORY_TEST, 8'h00, "factory");
    rd_chk(10'h3FF, 8'h00, "unmapped");
    aw(16'h4000, 16'h1234);
    rd_chk(`OFS_STATUS, 8'hD0, "no_divider");
    wr(`OFS_STATUS, 8'h30);
    wr(`OFS_DIVIDER, 8'h51);
    rd_chk(`OFS_DIVIDER, 8'hD1, "divider");
    $display("test reset_divider done");
    for (int k = 0; k < 4; k++)
    begin
      n_op = 0;
      aw(addrs[k], 16'hC3A5);
      wr(`OFS_COMMAND, codes[k]);
      rd_chk(`OFS_COMMAND, codes[k] & `CMD_BITS_MASK, "cmd_read");
      wr(`OFS_STATUS, 8'h80);
      wait_done;
      rd_chk(`OFS_STATUS, codes[k] == `CMD_ERASE_VERIFY ? 8'hC4 : 8'hC0, "status_done");
      `CHECK("op_count", codes[k] == `CMD_SECTOR_ERASE ? 256 : 1, n_op)
      `CHECK("op_cmd", codes[k], last_cmd)
      `CHECK("op_data", codes[k] == `CMD_PROGRAM ? 16'hC3A5 : 16'h0000, last_data)
      if (codes[k] == `CMD_PROGRAM) `CHECK("prog_addr", addrs[k], first_addr)
      if (codes[k] == `CMD_SECTOR_ERASE) `CHECK("sector_base", addrs[k] & 16'hFE00, first_addr)
    end
    $display("test commands done");
    for (int k = 0; k < 5; k++)
    begin
      aw(16'h4000, 16'h0000);
      if (k < 3) wr(`OFS_COMMAND, k == 0 ? 8'h21 : (k == 1 ? 8'h00 : 8'h45));
      if (k == 4) wr(`OFS_COMMAND, `CMD_PROGRAM);
      if (k > 2) wr(`OFS_STATUS, 8'h00);
      rd_chk(`OFS_STATUS, 8'hD0, "seq_abort");
      wr(`OFS_STATUS, 8'h30);
    end
    @(posedge clk_sys) other_bank_error <= 1'b1;
    n_op = 0;
    seq(16'h4000, 16'h0000, `CMD_PROGRAM);
    rd_chk(`OFS_STATUS, 8'hD0, "bank_block");
    `CHECK("blocked_ops", 0, n_op)
    @(posedge clk_sys) other_bank_error <= 1'b0;
    wr(`OFS_STATUS, 8'h30);
    @(posedge clk_sys) protect_hit <= 1'b1;
    aw(16'h4000, 16'h0000);
    rd_chk(`OFS_STATUS, 8'hE0, "protect");
    @(posedge clk_sys) protect_hit <= 1'b0;
    wr(`OFS_STATUS, 8'h30);
    $display("test errors done");
    @(posedge clk_sys) slow <= 1'b1;
    n_op = 0;
    seq(16'h4010, 16'hAAAA, `CMD_PROGRAM);
    rd_chk(`OFS_STATUS, 8'h80, "launched");
    seq(16'h4012, 16'h5555, `CMD_PROGRAM);
    #1 `CHECK("hv_keep", 1'b1, hv_keep)
    rd_chk(`OFS_STATUS, 8'h00, "queue_full");
    for (i = 0; i < 200 && n_op < 2; i++) @(posedge clk_sys);
    rd_chk(`OFS_STATUS, 8'h80, "pending_run");
    wait_done;
    `CHECK("second_data", 16'h5555, last_data)
    @(posedge clk_sys) slow <= 1'b0;
    $display("test queue done");
    @(posedge clk_sys) special_mode <= 1'b1;
    wr(`OFS_ADDR_HIGH, 8'hFF);
    rd_chk(`OFS_ADDR_HIGH, 8'h7F, "addr_high");
    wr(`OFS_ADDR_LOW, 8'h5A);
    rd_chk(`OFS_ADDR_LOW, 8'h5A, "addr_low");
    aw(16'h4000, 16'hBEEF);
    rd_chk(`OFS_DATA_HIGH, 8'hBE, "data_high");
    rd_chk(`OFS_DATA_LOW, 8'hEF, "data_low");
    wr(`OFS_STATUS, 8'h00);
    wr(`OFS_STATUS, 8'h30);
    @(posedge clk_sys) special_mode <= 1'b0;
    rd_chk(`OFS_ADDR_HIGH, 8'h00, "user_addr");
    rd_chk(`OFS_DATA_LOW, 8'h00, "user_data");
    $display("test special done");
    print_verdict;
  end
endmodule
